/* hdl/add_and_bit_test_exec.v */
`timescale 1ns/10ps
`include "exec_defines.vh"

module add_and_bit_test_exec #(
	parameter DW = `DATA_WIDTH,
	parameter AW = `ADDR_WIDTH
) (
	// Clock and reset
	input  wire                     clk,
	input  wire                     nrst,
	// Instruction from decoder
	input  wire                     issue,
	input  wire [`OP_WIDTH-1:0]     op_select,
	input  wire [DW-1:0]            literal,
	input  wire [AW-1:0]            file_addr,
	input  wire                     dest_select,
	input  wire [`BITSEL_WIDTH-1:0] bit_select,
	// File register read data
	input  wire [DW-1:0]            file_rdata,
	input  wire                     file_is_port,
	input  wire [DW-1:0]            port_pins,
	// File register write
	output reg                      file_we,
	output reg  [AW-1:0]            file_waddr,
	output reg  [DW-1:0]            file_wdata,
	// Architectural state
	output reg  [DW-1:0]            accumulator,
	output reg                      carry_flag,
	output reg                      digit_carry_flag,
	output reg                      zero_flag,
	// Sequencing
	output reg                      busy,
	output reg                      discard_next,
	output reg                      no_operation,
	output reg                      done
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_EXEC = 2'b01;
	localparam ST_NOP  = 2'b10;

	reg [1:0] state_q;
	reg [1:0] state_d;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function [DW-1:0] bit_mask;
		input [`BITSEL_WIDTH-1:0] pos;
		begin
			bit_mask = {{(DW-1){1'b0}}, 1'b1} << pos;
		end
	endfunction

	// Exact compares: an illegal multi-hot code does nothing
	function is_add;
		input [`OP_WIDTH-1:0] op;
		begin
			is_add = (op == `OP_ADD_LIT) || (op == `OP_ADD_FILE);
		end
	endfunction

	function is_and;
		input [`OP_WIDTH-1:0] op;
		begin
			is_and = (op == `OP_AND_LIT) || (op == `OP_AND_FILE);
		end
	endfunction

	function is_lit;
		input [`OP_WIDTH-1:0] op;
		begin
			is_lit = (op == `OP_ADD_LIT) || (op == `OP_AND_LIT);
		end
	endfunction

	function skip_hit;
		input [`OP_WIDTH-1:0] op;
		input                 bit_val;
		begin
			skip_hit = ((op == `OP_SKIP_IF_CLEAR) && !bit_val) ||
				((op == `OP_SKIP_IF_SET) && bit_val);
		end
	endfunction

	// ----------------------------------------
	// Operand and ALU
	// ----------------------------------------
	// Port registers reread the pins so an externally held level is written back
	wire [DW-1:0] file_src = file_is_port ? port_pins : file_rdata;
	wire          lit_op   = is_lit(op_select);
	wire          and_op   = is_and(op_select);
	wire [DW-1:0] opb      = lit_op ? literal : file_src;
	wire [DW-1:0] alu_res;
	wire          alu_c;
	wire          alu_dc;
	wire          alu_z;
	wire [DW-1:0] sel_mask = bit_mask(bit_select);
	wire          tested   = |(file_src & sel_mask);
	wire [DW-1:0] set_byte;
	wire [DW-1:0] clr_byte;

	// ----------------------------------------
	// Single-bit modify
	// ----------------------------------------
	// One lane per bit; untouched bits copy the source, pins included for ports
	genvar gi;
	generate
		for (gi = 0; gi < DW; gi = gi + 1) begin : g_lane
			assign set_byte[gi] = file_src[gi] | sel_mask[gi];
			assign clr_byte[gi] = file_src[gi] & ~sel_mask[gi];
		end
	endgenerate

	exec_alu #(
		.WIDTH(DW)
	) exec_alu_i (
		.opa       (accumulator),
		.opb       (opb),
		.do_and    (and_op),
		.result    (alu_res),
		.carry_out (alu_c),
		.digit_out (alu_dc),
		.zero_out  (alu_z)
	);

	always @* begin
		state_d = ST_EXEC;
		case (state_q)
			ST_EXEC: begin
				if (issue && skip_hit(op_select, tested))
					state_d = ST_NOP;
			end
			ST_NOP:  state_d = ST_EXEC;
			default: state_d = ST_EXEC;
		endcase
	end

	// ----------------------------------------
	// Execute
	// ----------------------------------------
	always @(posedge clk) begin
		if (!nrst) begin
			state_q          <= ST_EXEC;
			accumulator      <= `ACC_RESET;
			carry_flag       <= `FLAG_RESET;
			digit_carry_flag <= `FLAG_RESET;
			zero_flag        <= `FLAG_RESET;
			file_we          <= 1'b0;
			file_waddr       <= {AW{1'b0}};
			file_wdata       <= `BYTE_ZERO;
			busy             <= 1'b0;
			discard_next     <= 1'b0;
			no_operation     <= 1'b0;
			done             <= 1'b0;
		end else begin
			state_q      <= state_d;
			file_we      <= 1'b0;
			file_waddr   <= file_addr;
			discard_next <= 1'b0;
			done         <= 1'b0;
			busy         <= (state_d == ST_NOP);
			no_operation <= (state_q == ST_NOP);
			if (state_q == ST_NOP) begin
				// Instruction fetched during the skip is dropped whole
				done <= 1'b1;
			end else if (issue) begin
				done <= (state_d == ST_EXEC);
				discard_next <= (state_d == ST_NOP);
				case (op_select)
					`OP_ADD_LIT, `OP_AND_LIT: begin
						accumulator <= alu_res;
					end
					`OP_ADD_FILE, `OP_AND_FILE: begin
						if (dest_select == `DEST_FILE) begin
							file_we    <= 1'b1;
							file_wdata <= alu_res;
						end else begin
							accumulator <= alu_res;
						end
					end
					`OP_BIT_CLEAR: begin
						file_we    <= 1'b1;
						file_wdata <= clr_byte;
					end
					`OP_BIT_SET: begin
						file_we    <= 1'b1;
						file_wdata <= set_byte;
					end
					default: begin
					end
				endcase
				if (is_add(op_select)) begin
					carry_flag       <= alu_c;
					digit_carry_flag <= alu_dc;
					zero_flag        <= alu_z;
				end
				if (is_and(op_select))
					zero_flag <= alu_z;
			end
		end
	end
endmodule

/* shared/exec_defines.vh */
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH

// ----------------------------------------
// Operation select codes (one-hot)
// ----------------------------------------
`define OP_WIDTH             8
`define OP_ADD_LIT           8'h01
`define OP_ADD_FILE          8'h02
`define OP_AND_LIT           8'h04
`define OP_AND_FILE          8'h08
`define OP_BIT_CLEAR         8'h10
`define OP_BIT_SET           8'h20
`define OP_SKIP_IF_CLEAR     8'h40
`define OP_SKIP_IF_SET       8'h80

// ----------------------------------------
// Datapath layout
// ----------------------------------------
`define DATA_WIDTH           8
`define ADDR_WIDTH           7
`define BITSEL_WIDTH         3
`define NIBBLE_TOP           3
`define BYTE_TOP             7
`define DEST_ACCUMULATOR     1'b0
`define DEST_FILE            1'b1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACC_RESET            8'h00
`define BYTE_ZERO            8'h00
`define FLAG_RESET           1'b0

`endif

/* hdl/exec_alu.v */
`timescale 1ns/10ps
`include "exec_defines.vh"

// ----------------------------------------
// Combinational add / and unit
// ----------------------------------------
module exec_alu #(
	parameter WIDTH = `DATA_WIDTH
) (
	// Operands
	input  wire [WIDTH-1:0] opa,
	input  wire [WIDTH-1:0] opb,
	input  wire             do_and,
	// Results
	output reg  [WIDTH-1:0] result,
	output reg              carry_out,
	output reg              digit_out,
	output reg              zero_out
);
	reg [WIDTH:0] sum;
	reg [`NIBBLE_TOP+1:0] low;

	always @* begin
		sum       = {1'b0, opa} + {1'b0, opb};
		low       = {1'b0, opa[`NIBBLE_TOP:0]} + {1'b0, opb[`NIBBLE_TOP:0]};
		result    = do_and ? (opa & opb) : sum[WIDTH-1:0];
		carry_out = sum[WIDTH];
		digit_out = low[`NIBBLE_TOP+1];
		zero_out  = (result == {WIDTH{1'b0}});
	end
endmodule

/* test/exec_check_sva.sv */
`timescale 1ns/10ps
module exec_check (
	// Watched ports
	input wire logic       clk, nrst, issue, busy, file_is_port, dest_select, file_we,
	input wire logic       discard_next, done, carry_flag, digit_carry_flag, zero_flag,
	input wire logic [7:0] op_select, literal, file_rdata, port_pins, file_wdata, accumulator,
	input wire logic [2:0] bit_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Pins stand in for port registers
	wire       go  = issue && !busy;
	wire [7:0] src = file_is_port ? port_pins : file_rdata;
	wire [7:0] opb = (op_select[0] || op_select[2]) ? literal : src;
	reg  [8:0] sum_q;
	reg        dc_q;
	reg  [7:0] and_q;
	reg  [2:0] b_q;
	reg  [7:0] src_q;
	always @(posedge clk) begin
		sum_q <= {1'b0, accumulator} + {1'b0, opb};
		dc_q  <= ({1'b0, accumulator[3:0]} + {1'b0, opb[3:0]}) > 5'h0F;
		and_q <= accumulator & opb;
		b_q   <= bit_select;
		src_q <= src;
	end
	AST_ADD_LIT: assert property (go && op_select == 8'h01 |=> accumulator == sum_q[7:0] &&
		carry_flag == sum_q[8] && digit_carry_flag == dc_q && zero_flag == (sum_q[7:0] == 8'h00))
		else $error("add literal result or flags wrong");
	AST_ADD_FILE: assert property (go && op_select == 8'h02 && dest_select |=> file_we &&
		file_wdata == sum_q[7:0] && carry_flag == sum_q[8] && $stable(accumulator))
		else $error("add file write wrong");
	AST_AND_LIT: assert property (go && op_select == 8'h04 |=> accumulator == and_q &&
		zero_flag == (and_q == 8'h00) && $stable(carry_flag)) else $error("and literal wrong");
	AST_AND_FILE: assert property (go && op_select == 8'h08 && dest_select |=> file_we &&
		file_wdata == and_q && $stable(digit_carry_flag)) else $error("and file wrong");
	AST_BIT_CLEAR: assert property (go && op_select == 8'h10 |=> file_we &&
		file_wdata == (src_q & ~(8'h01 << b_q)) && $stable(zero_flag))
		else $error("bit clear wrong");
	AST_BIT_SET: assert property (go && op_select == 8'h20 |=> file_we &&
		file_wdata == (src_q | (8'h01 << b_q)) && $stable(carry_flag))
		else $error("bit set wrong");
	AST_SKIP_CLEAR: assert property (go && op_select == 8'h40 && !src[bit_select] |=>
		busy && discard_next ##1 done && !busy) else $error("skip if clear wrong");
	AST_SKIP_SET: assert property (go && op_select == 8'h80 && src[bit_select] |=>
		busy && discard_next ##1 done && !busy) else $error("skip if set wrong");
	cover property (go && op_select == 8'h40 ##1 discard_next);
	cover property (go && file_is_port ##1 file_we);
	cover property (go && op_select == 8'h01 ##1 carry_flag);
endmodule

bind add_and_bit_test_exec exec_check exec_check_i (.*);

/* test/file_model.sv */
`timescale 1ns/10ps
module file_model #(parameter PORT_ADDR = 7'h06) (
	input wire logic       clk, file_we,
	input wire logic [6:0] file_addr, file_waddr,
	input wire logic [7:0] file_wdata,
	output logic [7:0]     file_rdata,
	output logic           file_is_port
);
	// Each cell starts at its own address
	logic [7:0] mem [0:127];
	initial for (int i = 0; i < 128; i++) mem[i] = i[7:0];
	assign file_rdata   = mem[file_addr];
	assign file_is_port = (file_addr == PORT_ADDR);
	always @(posedge clk) if (file_we) mem[file_waddr] <= file_wdata;
endmodule

/* test/add_and_bit_test_exec_tb.sv */
`timescale 1ns/10ps
module add_and_bit_test_exec_tb;
	logic clk = 0, nrst = 0, issue = 0, dest_select = 0, file_is_port, file_we;
	logic carry_flag, digit_carry_flag, zero_flag, busy, discard_next, no_operation, done;
	logic [7:0] op_select = 8'h00, literal = 8'h00, port_pins = 8'h3C, file_rdata, file_wdata;
	logic [7:0] accumulator;
	logic [6:0] file_addr = 7'h00, file_waddr;
	logic [2:0] bit_select = 3'h0;
	int         fail_count = 0, n_tests = 0;
	wire [11:0] st = {1'b0, carry_flag, digit_carry_flag, zero_flag, accumulator};
	wire [11:0] wr = {3'h0, file_we, file_wdata};
	always #2 clk = ~clk;
	add_and_bit_test_exec add_and_bit_test_exec_i (.*);
	file_model file_model_i (.*);
	task check(input logic [11:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task run(input [7:0] op, k, input [6:0] a, input d, input [2:0] b);
		@(posedge clk) #1;
		{issue, op_select, literal, file_addr, dest_select, bit_select} = {1'b1, op, k, a, d, b};
		@(posedge clk) #1 issue = 0;
		for (int i = 0; i < 4 && done !== 1'b1; i++) @(posedge clk) #1;
		if (done !== 1'b1) begin
			fail_count++;
			summarize;
		end
	endtask
	task sc_add;
		run(8'h02, 8'h00, 7'h10, 1'b1, 3'h0);
		check(wr, 12'h110);
		check({5'h00, file_waddr}, 12'h010);
		check(st, 12'h000);
		run(8'h02, 8'h00, 7'h1C, 1'b0, 3'h0);
		check({3'h0, file_we, accumulator}, 12'h01C);
		run(8'h01, 8'hF4, 7'h00, 1'b0, 3'h0);
		check(st, 12'h610);
	endtask
	task sc_and;
		run(8'h08, 8'h00, 7'h06, 1'b1, 3'h0);
		check(wr, 12'h110);
		check(st, 12'h610);
		run(8'h04, 8'h0F, 7'h00, 1'b0, 3'h0);
		check(st, 12'h700);
	endtask
	task sc_bits;
		run(8'h20, 8'h00, 7'h21, 1'b0, 3'h7);
		check(wr, 12'h1A1);
		run(8'h10, 8'h00, 7'h21, 1'b0, 3'h0);
		check(wr, 12'h1A0);
		check(st, 12'h700);
		run(8'h40, 8'h00, 7'h21, 1'b0, 3'h7);
		check({9'h000, busy, discard_next, done}, 12'h001);
		run(8'h80, 8'h00, 7'h21, 1'b0, 3'h0);
		check({9'h000, busy, discard_next, done}, 12'h001);
	endtask
	// Second issue lands in the busy cycle and must vanish
	task sc_skip(input [7:0] op, input [2:0] b);
		@(posedge clk) #1;
		{issue, op_select, literal, file_addr, bit_select} = {1'b1, op, 8'h55, 7'h21, b};
		@(posedge clk) #1 op_select = 8'h01;
		check({9'h000, busy, discard_next, done}, 12'h006);
		@(posedge clk) #1 issue = 0;
		check({1'b0, busy, no_operation, done, accumulator}, 12'h300);
		@(posedge clk) #1 check(st, 12'h700);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 nrst = 1;
		check(st, 12'h000);
		sc_add;
		sc_and;
		sc_bits;
		sc_skip(8'h40, 3'h0);
		sc_skip(8'h80, 3'h7);
		summarize;
	end
endmodule
